// File: inc/can_regs_pkg.sv
/*
  Constants, field positions and types of the CAN status, timing and filter registers.
  Assumes one 125 MHz clock and word-indexed Avalon-MM register access.
*/
package can_regs_pkg;
  localparam int unsigned CLK_FREQ_MHZ = 125;

  // Word indices; byte address is four times the index
  localparam logic [3:0] IDX_FIFO     = 4'h0;
  localparam logic [3:0] IDX_FLAG     = 4'h1;
  localparam logic [3:0] IDX_ENABLE   = 4'h2;
  localparam logic [3:0] IDX_ERRCNT   = 4'h3;
  localparam logic [3:0] IDX_PRESCALE = 4'h4;
  localparam logic [3:0] IDX_SEGMENTS = 4'h5;
  localparam logic [3:0] IDX_FILT_EN  = 4'h6;
  localparam logic [3:0] IDX_BUFSEL   = 4'h7;

  localparam logic [7:0]  FLAG_RST     = 8'h00;
  localparam logic [7:0]  ENABLE_RST   = 8'h00;
  localparam logic [7:0]  PRESCALE_RST = 8'h00;
  localparam logic [15:0] SEGMENTS_RST = 16'h0000;
  localparam logic [15:0] FILT_EN_RST  = 16'hffff;
  localparam logic [15:0] BUFSEL_RST   = 16'h0000;

  localparam logic [7:0]  EVENT_MASK    = 8'hef;
  localparam logic [15:0] SEGMENTS_MASK = 16'h47ff;

  // Event flag positions
  localparam int EV_INVALID = 7;
  localparam int EV_WAKE    = 6;
  localparam int EV_ERR     = 5;
  localparam int EV_FIFO    = 3;
  localparam int EV_OVF     = 2;
  localparam int EV_RX      = 1;
  localparam int EV_TX      = 0;

  // Error state positions, sitting at flag register bits 13:8
  localparam int ES_LSB  = 8;
  localparam int ES_TX_OFF     = 5;
  localparam int ES_TX_PASSIVE = 4;
  localparam int ES_RX_PASSIVE = 3;
  localparam int ES_TXW  = 2;
  localparam int ES_RXW  = 1;
  localparam int ES_ANYW = 0;

  localparam int FIFO_WR_LSB = 8;
  localparam int FIFO_RD_LSB = 0;
  localparam int JUMP_LSB      = 6;
  localparam int PRESCALER_LSB = 0;
  localparam int WAKE_FILT_BIT = 14;
  localparam int PH2_LSB       = 8;
  localparam int PH2SEL_BIT    = 7;
  localparam int TRIPLE_BIT    = 6;
  localparam int PH1_LSB     = 3;
  localparam int PROP_LSB    = 0;

  localparam logic [7:0] WARN_LIMIT    = 8'h60;
  localparam logic [7:0] PASSIVE_LIMIT = 8'h80;

  // Information processing time, coded as length minus one quantum
  localparam logic [2:0] INFO_TIME_CODE = 3'h1;

  // Least low time of the receive line that counts as wake-up
  localparam int unsigned WAKE_FILT_NS     = 1000;
  localparam int unsigned WAKE_FILT_CYCLES = (WAKE_FILT_NS * CLK_FREQ_MHZ + 999) / 1000;

  typedef enum logic [3:0] {
    SEG_SYNC = 4'h1,
    SEG_PROP = 4'h2,
    SEG_PH1  = 4'h4,
    SEG_PH2  = 4'h8
  } seg_state_t;

  typedef struct packed {
    logic [5:0] prescaler;
    logic [1:0] jump_width;
    logic [2:0] prop;
    logic [2:0] ph1;
    logic [2:0] ph2;
    logic       ph2_sel;
    logic       triple;
  } timing_cfg_t;
endpackage

// File: src/can_bit_timing.sv
/*
  Time quantum prescaler and nominal bit segment sequencer with sampling.
  Assumes configuration is stable while the bus is in use.
*/
module can_bit_timing
  import can_regs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire timing_cfg_t cfg_i,
  input  wire logic        rx_i,
  output logic             tq_tick_o,
  output logic             sample_o,
  output logic             sample_bit_o
);
  typedef struct packed {
    seg_state_t seg;
    logic [6:0] pre_cnt;
    logic [3:0] tq_cnt;
    logic [3:0] ext;
    logic [1:0] hist;
    logic       rx_prev;
    logic       tick;
    logic       sample;
    logic       bit_val;
  } bt_t;

  bt_t st_reg;
  bt_t st_next;
  logic       tick;
  logic       edge_seen;
  logic [2:0] ph2_code;
  logic [3:0] jump;

  assign tick      = st_reg.pre_cnt == {cfg_i.prescaler, 1'b1}; // RQ15
  assign edge_seen = st_reg.rx_prev && !rx_i;
  assign jump      = {2'h0, cfg_i.jump_width} + 4'h1; // RQ14
  assign ph2_code  = cfg_i.ph2_sel ? cfg_i.ph2 : // RQ26
                     (cfg_i.ph1 > INFO_TIME_CODE ? cfg_i.ph1 : INFO_TIME_CODE);

  always_comb begin
    st_next = st_reg;
    st_next.rx_prev = rx_i;
    st_next.tick = tick;
    st_next.sample = 1'b0;
    st_next.pre_cnt = tick ? 7'h00 : st_reg.pre_cnt + 7'h01;
    if (tick) begin
      st_next.hist = {st_reg.hist[0], rx_i};
    end
    case (st_reg.seg)
      SEG_SYNC: begin
        if (tick) begin
          st_next.seg = SEG_PROP; // RQ27
          st_next.tq_cnt = 4'h0;
        end
      end
      SEG_PROP: begin
        if (tick) begin
          st_next.tq_cnt = st_reg.tq_cnt + 4'h1;
          if (st_reg.tq_cnt == {1'b0, cfg_i.prop}) begin // RQ20
            st_next.seg = SEG_PH1;
            st_next.tq_cnt = 4'h0;
          end
        end
      end
      SEG_PH1: begin
        if (edge_seen && st_reg.ext == 4'h0) begin
          st_next.ext = jump;
        end
        if (tick) begin
          st_next.tq_cnt = st_reg.tq_cnt + 4'h1;
          if (st_reg.tq_cnt >= {1'b0, cfg_i.ph1} + st_reg.ext) begin // RQ19
            st_next.seg = SEG_PH2;
            st_next.tq_cnt = 4'h0;
            st_next.ext = 4'h0;
            st_next.sample = 1'b1;
            // Majority of the last three quanta
            st_next.bit_val = cfg_i.triple ? // RQ18
              (st_reg.hist[1] & st_reg.hist[0]) | (st_reg.hist[1] & rx_i) | (st_reg.hist[0] & rx_i) : rx_i;
          end
        end
      end
      SEG_PH2: begin
        if (edge_seen || tick) begin
          st_next.tq_cnt = st_reg.tq_cnt + (edge_seen ? jump : 4'h1);
          if (st_reg.tq_cnt + (edge_seen ? jump : 4'h0) >= {1'b0, ph2_code}) begin // RQ17
            st_next.seg = SEG_SYNC;
            st_next.tq_cnt = 4'h0;
          end
        end
      end
      default: begin
        st_next.seg = SEG_SYNC;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '{seg: SEG_SYNC, rx_prev: 1'b1, hist: 2'h3, bit_val: 1'b1, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign tq_tick_o    = st_reg.tick;
  assign sample_o     = st_reg.sample;
  assign sample_bit_o = st_reg.bit_val;

  sync_one_tq_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ27
    st_reg.seg == SEG_SYNC && tick |=> st_reg.seg == SEG_PROP)
    else $error("sync segment not one quantum");
endmodule

// File: src/can_status_timing_filter_regs.sv
/*
  CAN status, event flag, error count, bit timing and acceptance filter registers.
  Assumes an Avalon-MM master on CLK_I and a protocol engine that supplies
  pointers, error counts, event strobes and per-filter match lines.
*/
// Added by the designer: the Avalon-MM interface to the registers and the register addresses.
// Functional notes
// (RQ1) Two read-only 6-bit fifo pointers, reset zero
// (RQ2) Bit 13 shows transmitter bus-off
// (RQ3) Bits 12, 11 show tx, rx passive
// (RQ4) Bits 10, 9 warnings; bit 8 either
// (RQ5) Error flag set by error state changes; code sets it only when an error state is entered, not when one is left
// (RQ6) Invalid message sets bit 7; clear-only flags
// (RQ7) Bus activity sets wake-up flag
// (RQ8) Fifo almost full sets bit 3
// (RQ9) Occupied target buffer sets overflow flag
// (RQ10) Receive sets bit 1, transmit bit 0
// (RQ11) Enable bits beside each flag, reset zero
// (RQ12) Transmit error count in bits 15-8
// (RQ13) Receive error count in bits 7-0
// (RQ14) Jump width is field plus one quanta
// (RQ15) Quantum is twice prescaler plus one clocks
// (RQ16) Bit 14 enables wake-up line filter
// (RQ17) Phase two is field plus one quanta
// (RQ18) Bit 6 selects triple sampling
// (RQ19) Phase one is field plus one quanta
// (RQ20) Propagation is field plus one quanta
// (RQ21) Filter accepts only while enabled, reset one
// (RQ22) Filters 0-3 store into pointed buffer
// (RQ23) Pointer value is the buffer number
// (RQ24) Wake-up works while disabled; rest frozen
// (RQ25) Interrupt on any enabled set flag
// (RQ26) Bit 7 picks phase two source
// (RQ27) Bit is sync, prop, phase one, two
module can_status_timing_filter_regs
  import can_regs_pkg::*;
(
  input  wire logic        CLK_I,
  input  wire logic        RST_N_I,
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic      [31:0] AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O,
  input  wire logic        MODULE_DISABLE_I,
  input  wire logic        CAN_RX_I,
  input  wire logic [5:0]  FIFO_WR_PTR_I,
  input  wire logic [5:0]  FIFO_RD_PTR_I,
  input  wire logic [7:0]  TX_ERR_COUNT_I,
  input  wire logic [7:0]  RX_ERR_COUNT_I,
  input  wire logic        TX_BUS_OFF_I,
  input  wire logic        RX_INVALID_I,
  input  wire logic        RX_DONE_I,
  input  wire logic        RX_OVERFLOW_I,
  input  wire logic        TX_DONE_I,
  input  wire logic        FIFO_ALMOST_FULL_I,
  input  wire logic        MSG_DONE_I,
  input  wire logic [15:0] FILTER_HIT_I,
  output logic             IRQ_O,
  output logic             TQ_TICK_O,
  output logic             SAMPLE_O,
  output logic             SAMPLE_BIT_O,
  output logic             ACCEPT_O,
  output logic      [3:0]  ACCEPT_FILTER_O,
  output logic      [3:0]  ACCEPT_BUF_O,
  output logic             ACCEPT_BUF_VALID_O
);
  typedef struct packed {
    logic        wait_req;
    logic [31:0] rdata;
    logic [7:0]  flags;
    logic [7:0]  enable;
    logic [5:0]  fifo_wr;
    logic [5:0]  fifo_rd;
    logic [7:0]  tec;
    logic [7:0]  rec;
    logic        bus_off;
    logic [5:0]  err_state;
    logic [7:0]  prescale;
    logic [15:0] segments;
    logic [15:0] filt_en;
    logic [15:0] bufsel;
    logic        irq;
    logic        accept;
    logic [3:0]  acc_filter;
    logic [3:0]  acc_buf;
    logic        acc_buf_valid;
  } regs_t;

  localparam regs_t REGS_RST = '{
    wait_req: 1'b1,
    flags:    FLAG_RST,
    enable:   ENABLE_RST,
    prescale: PRESCALE_RST,
    segments: SEGMENTS_RST,
    filt_en:  FILT_EN_RST,
    bufsel:   BUFSEL_RST,
    default:  '0
  };

  regs_t       st_reg;
  regs_t       st_next;
  logic        wr_commit;
  logic        rd_take;
  logic        flag_wr;
  logic [15:0] wmask;
  logic [15:0] wdata;
  logic [15:0] rd_word;
  logic [5:0]  es_now;
  logic [7:0]  ev_set;
  logic [15:0] eligible;
  logic [3:0]  hit_idx;
  logic        wake_pulse;
  timing_cfg_t cfg;

  function automatic logic [15:0] merge16(input logic [15:0] old_v, input logic [15:0] new_v,
                                          input logic [15:0] mask);
    return (old_v & ~mask) | (new_v & mask);
  endfunction

  // Request is answered one cycle after it is first seen
  assign wr_commit = AVS_WRITE_I && !st_reg.wait_req;
  assign rd_take   = AVS_READ_I && st_reg.wait_req;
  assign flag_wr   = wr_commit && AVS_ADDRESS_I == IDX_FLAG && AVS_BYTEENABLE_I[0];
  assign wmask     = {{8{AVS_BYTEENABLE_I[1]}}, {8{AVS_BYTEENABLE_I[0]}}};
  assign wdata     = AVS_WRITEDATA_I[15:0];

  // Error states from the held counters
  assign es_now[ES_TX_OFF]     = st_reg.bus_off; // RQ2
  assign es_now[ES_TX_PASSIVE] = st_reg.tec >= PASSIVE_LIMIT; // RQ3
  assign es_now[ES_RX_PASSIVE] = st_reg.rec >= PASSIVE_LIMIT; // RQ3
  assign es_now[ES_TXW]  = st_reg.tec >= WARN_LIMIT; // RQ4
  assign es_now[ES_RXW]  = st_reg.rec >= WARN_LIMIT; // RQ4
  assign es_now[ES_ANYW] = es_now[ES_TXW] | es_now[ES_RXW]; // RQ4

  // Event sources; only wake-up passes while disabled
  always_comb begin
    ev_set = 8'h00;
    ev_set[EV_WAKE] = wake_pulse; // RQ7 RQ24
    if (!MODULE_DISABLE_I) begin
      ev_set[EV_INVALID] = RX_INVALID_I; // RQ6
      ev_set[EV_ERR]     = |(es_now & ~st_reg.err_state); // RQ5
      ev_set[EV_FIFO]    = FIFO_ALMOST_FULL_I; // RQ8
      ev_set[EV_OVF]     = RX_OVERFLOW_I; // RQ9
      ev_set[EV_RX]      = RX_DONE_I; // RQ10
      ev_set[EV_TX]      = TX_DONE_I; // RQ10
    end
  end

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : gen_filt
      assign eligible[g] = FILTER_HIT_I[g] & st_reg.filt_en[g]; // RQ21
    end
  endgenerate

  // Lowest numbered enabled filter wins
  always_comb begin
    hit_idx = 4'h0;
    for (int i = 15; i >= 0; i--) begin
      if (eligible[i]) begin
        hit_idx = 4'(i);
      end
    end
  end

  always_comb begin
    case (AVS_ADDRESS_I)
      IDX_FIFO:     rd_word = {2'h0, st_reg.fifo_wr, 2'h0, st_reg.fifo_rd}; // RQ1
      IDX_FLAG:     rd_word = {2'h0, st_reg.err_state, st_reg.flags};
      IDX_ENABLE:   rd_word = {8'h00, st_reg.enable};
      IDX_ERRCNT:   rd_word = {st_reg.tec, st_reg.rec}; // RQ12 RQ13
      IDX_PRESCALE: rd_word = {8'h00, st_reg.prescale};
      IDX_SEGMENTS: rd_word = st_reg.segments;
      IDX_FILT_EN:  rd_word = st_reg.filt_en;
      IDX_BUFSEL:   rd_word = st_reg.bufsel;
      default:      rd_word = 16'h0000;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.wait_req = !((AVS_READ_I || AVS_WRITE_I) && st_reg.wait_req);
    if (rd_take) begin
      st_next.rdata = {16'h0000, rd_word};
    end

    // Counters and pointers hold while disabled
    if (!MODULE_DISABLE_I) begin
      st_next.fifo_wr = FIFO_WR_PTR_I; // RQ1
      st_next.fifo_rd = FIFO_RD_PTR_I; // RQ1
      st_next.tec     = TX_ERR_COUNT_I; // RQ12 RQ24
      st_next.rec     = RX_ERR_COUNT_I; // RQ13 RQ24
      st_next.bus_off = TX_BUS_OFF_I;
    end
    st_next.err_state = es_now;

    // Clear by writing zero; a new event wins
    if (flag_wr) begin
      st_next.flags = st_reg.flags & wdata[7:0]; // RQ6
    end
    st_next.flags = (st_next.flags | ev_set) & EVENT_MASK;

    if (wr_commit) begin
      case (AVS_ADDRESS_I)
        IDX_ENABLE: begin
          st_next.enable = 8'(merge16({8'h00, st_reg.enable}, wdata, wmask)
                              & {8'h00, EVENT_MASK}); // RQ11
        end
        IDX_PRESCALE: begin
          st_next.prescale = 8'(merge16({8'h00, st_reg.prescale}, wdata, wmask)); // RQ14 RQ15
        end
        IDX_SEGMENTS: begin
          st_next.segments = merge16(st_reg.segments, wdata, wmask) & SEGMENTS_MASK;
        end
        IDX_FILT_EN: begin
          st_next.filt_en = merge16(st_reg.filt_en, wdata, wmask); // RQ21
        end
        IDX_BUFSEL: begin
          st_next.bufsel = merge16(st_reg.bufsel, wdata, wmask); // RQ22
        end
        default: begin
        end
      endcase
    end

    st_next.irq = |(st_reg.flags & st_reg.enable); // RQ25

    st_next.accept = MSG_DONE_I && !MODULE_DISABLE_I && |eligible;
    if (MSG_DONE_I) begin
      st_next.acc_filter    = hit_idx;
      st_next.acc_buf_valid = hit_idx < 4'h4;
      st_next.acc_buf       = st_reg.bufsel[{hit_idx[1:0], 2'h0} +: 4]; // RQ22 RQ23
    end
  end

  always_ff @(posedge CLK_I) begin
    if (!RST_N_I) begin
      st_reg <= REGS_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  always_comb begin
    cfg.prescaler  = st_reg.prescale[PRESCALER_LSB +: 6]; // RQ15
    cfg.jump_width = st_reg.prescale[JUMP_LSB +: 2]; // RQ14
    cfg.prop       = st_reg.segments[PROP_LSB +: 3]; // RQ20
    cfg.ph1        = st_reg.segments[PH1_LSB +: 3]; // RQ19
    cfg.ph2        = st_reg.segments[PH2_LSB +: 3]; // RQ17
    cfg.ph2_sel    = st_reg.segments[PH2SEL_BIT]; // RQ26
    cfg.triple     = st_reg.segments[TRIPLE_BIT]; // RQ18
  end

  can_bit_timing u_timing (
    .clk_i        (CLK_I),
    .rst_n_i      (RST_N_I),
    .cfg_i        (cfg),
    .rx_i         (CAN_RX_I),
    .tq_tick_o    (TQ_TICK_O),
    .sample_o     (SAMPLE_O),
    .sample_bit_o (SAMPLE_BIT_O)
  );

  can_wake_filter u_wake (
    .clk_i       (CLK_I),
    .rst_n_i     (RST_N_I),
    .filter_en_i (st_reg.segments[WAKE_FILT_BIT]), // RQ16
    .rx_i        (CAN_RX_I),
    .wake_o      (wake_pulse)
  );

  assign AVS_READDATA_O     = st_reg.rdata;
  assign AVS_WAITREQUEST_O  = st_reg.wait_req;
  assign IRQ_O              = st_reg.irq;
  assign ACCEPT_O           = st_reg.accept;
  assign ACCEPT_FILTER_O    = st_reg.acc_filter;
  assign ACCEPT_BUF_O       = st_reg.acc_buf;
  assign ACCEPT_BUF_VALID_O = st_reg.acc_buf_valid;

  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!RST_N_I);

  sequence read_req_s;
    AVS_READ_I && AVS_WAITREQUEST_O;
  endsequence

  sequence busoff_in_s;
    TX_BUS_OFF_I && !MODULE_DISABLE_I;
  endsequence

  read_answer_a: assert property (read_req_s |=> !AVS_WAITREQUEST_O)
    else $error("read not answered next cycle");

  fifo_ptr_a: assert property (!MODULE_DISABLE_I |=> st_reg.fifo_wr == $past(FIFO_WR_PTR_I)) // RQ1
    else $error("fifo pointer not captured");

  busoff_state_a: assert property (busoff_in_s ##1 1'b1 |=> st_reg.err_state[ES_TX_OFF]) // RQ2
    else $error("bus-off state not shown");

  tx_passive_a: assert property (1'b1 |=> st_reg.err_state[ES_TX_PASSIVE] == ($past(st_reg.tec) >= PASSIVE_LIMIT)) // RQ3
    else $error("tx passive wrong");

  any_warn_a: assert property (1'b1 |=> st_reg.err_state[ES_ANYW] == // RQ4
    ($past(st_reg.tec) >= WARN_LIMIT || $past(st_reg.rec) >= WARN_LIMIT))
    else $error("combined warning wrong");

  err_event_a: assert property (!MODULE_DISABLE_I && |(es_now & ~st_reg.err_state) |=> st_reg.flags[EV_ERR]) // RQ5
    else $error("error event not flagged");

  invalid_hold_a: assert property (st_reg.flags[EV_INVALID] && !(flag_wr && !wdata[EV_INVALID]) // RQ6
    |=> st_reg.flags[EV_INVALID])
    else $error("invalid flag lost");

  invalid_set_a: assert property (RX_INVALID_I && !MODULE_DISABLE_I |=> st_reg.flags[EV_INVALID]) // RQ6
    else $error("invalid flag not set");

  wake_flag_a: assert property (wake_pulse |=> st_reg.flags[EV_WAKE]) // RQ7
    else $error("wake flag not set");

  counters_hold_a: assert property (MODULE_DISABLE_I |=> $stable(st_reg.tec) && $stable(st_reg.rec)) // RQ24
    else $error("counters moved while disabled");

  irq_follow_a: assert property (|(st_reg.flags & st_reg.enable) |=> IRQ_O ##1 1'b1) // RQ25
    else $error("interrupt not raised");

  filter_off_a: assert property (MSG_DONE_I && !(|eligible) |=> !ACCEPT_O) // RQ21
    else $error("disabled filter accepted");

  accept_buf_a: assert property (MSG_DONE_I && !MODULE_DISABLE_I && eligible[1:0] == 2'h2 // RQ22
    |=> ACCEPT_O && ACCEPT_BUF_O == $past(st_reg.bufsel[7:4]) && ACCEPT_BUF_VALID_O)
    else $error("filter one buffer wrong");
endmodule

// File: src/can_wake_filter.sv
/*
  Bus activity detector for wake-up, with optional low-pass filter.
  Assumes the receive line is synchronous to the clock.
*/
module can_wake_filter
  import can_regs_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic filter_en_i,
  input  wire logic rx_i,
  output logic      wake_o
);
  localparam logic [7:0] FILT_LAST = 8'(WAKE_FILT_CYCLES - 1);

  typedef struct packed {
    logic [7:0] cnt;
    logic       rx_prev;
    logic       wake;
  } wf_t;

  wf_t st_reg;
  wf_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.rx_prev = rx_i;
    st_next.wake = 1'b0;
    if (rx_i) begin
      st_next.cnt = 8'h00;
    end else if (st_reg.cnt <= FILT_LAST) begin
      st_next.cnt = st_reg.cnt + 8'h01;
    end
    // Filtered: dominant must last the full time
    if (filter_en_i) begin
      st_next.wake = !rx_i && st_reg.cnt == FILT_LAST;
    end else begin
      st_next.wake = st_reg.rx_prev && !rx_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '{rx_prev: 1'b1, default: '0};
    end else begin
      st_reg <= st_next;
    end
  end

  assign wake_o = st_reg.wake;
endmodule

// File: tb/can_bus_model.sv
/*
  Receive line of the CAN bus as seen through the transceiver.
  Assumes its task is called just after a rising clock edge.
*/
module can_bus_model (
  input  wire logic clk_i,
  output logic      rx_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // Recessive while idle
  initial rx_o = 1'b1;

  // Dominant for n clocks, then back to recessive
  task automatic dominant(input int n);
    rx_o <= 1'b0;
    repeat (n) @(posedge clk_i);
    rx_o <= 1'b1;
  endtask
endmodule

// File: tb/can_status_timing_filter_regs_tb.sv
/*
  Self-checking bench for the CAN status, timing and filter registers.
  Assumes the bus model on the receive line and a 125 MHz clock.
*/
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin err_count++; $display("Error at %0t: got %h, expected %h", $time, g, e); end end
module can_status_timing_filter_regs_tb import can_regs_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0, rst_n = 1'b0, rd = 1'b0, wr = 1'b0, dis = 1'b0, bo = 1'b0, msg = 1'b0;
  logic [3:0]  addr = 4'h0, be = 4'h3;
  logic [31:0] wdata = 32'h0;
  logic [5:0]  wp = 6'h00, rp = 6'h00;
  logic [7:0]  tc = 8'h00, rc = 8'h00;
  logic [4:0]  ev = 5'h00;
  logic [15:0] hit = 16'h0000;
  logic [31:0] rdata;
  logic        wait_req, rx, irq, tq, smp, sbit, acc, aval;
  logic [3:0]  afilt, abuf;
  int          err_count = 0, tests_run = 0;

  can_bus_model can_bus_model_i (.clk_i(clk), .rx_o(rx));

  can_status_timing_filter_regs can_status_timing_filter_regs_i (
    .CLK_I(clk), .RST_N_I(rst_n), .AVS_ADDRESS_I(addr), .AVS_READ_I(rd), .AVS_WRITE_I(wr),
    .AVS_WRITEDATA_I(wdata), .AVS_BYTEENABLE_I(be), .AVS_READDATA_O(rdata),
    .AVS_WAITREQUEST_O(wait_req), .MODULE_DISABLE_I(dis), .CAN_RX_I(rx), .FIFO_WR_PTR_I(wp),
    .FIFO_RD_PTR_I(rp), .TX_ERR_COUNT_I(tc), .RX_ERR_COUNT_I(rc), .TX_BUS_OFF_I(bo),
    .RX_INVALID_I(ev[4]), .RX_DONE_I(ev[1]), .RX_OVERFLOW_I(ev[2]), .TX_DONE_I(ev[0]),
    .FIFO_ALMOST_FULL_I(ev[3]), .MSG_DONE_I(msg), .FILTER_HIT_I(hit), .IRQ_O(irq),
    .TQ_TICK_O(tq), .SAMPLE_O(smp), .SAMPLE_BIT_O(sbit), .ACCEPT_O(acc),
    .ACCEPT_FILTER_O(afilt), .ACCEPT_BUF_O(abuf), .ACCEPT_BUF_VALID_O(aval)
  );

  initial begin
    forever #4 clk = ~clk;
  end

  task automatic stop_test;
    $display("Checks %0d, errors %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One transfer; held until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
    int n;
    @(posedge clk);
    addr <= a;
    wdata <= {16'h0000, d};
    rd <= ~w;
    wr <= w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (wait_req !== 1'b0 && n < 50);
    if (wait_req !== 1'b0) begin
      err_count++;
      stop_test();
    end
    q = rdata[15:0];
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wr16(input logic [3:0] a, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] q;
    bus(1'b0, a, 16'h0000, q);
    `CHK(q, e)
  endtask

  task automatic pulse(input logic [4:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 5'h00;
  endtask

  // Spacing of the second and third tick or sample pulses; earlier ones may straddle a reconfiguration
  task automatic gap(input logic s, input int e);
    int k, m;
    for (k = 0; k < 3; k++) begin
      m = 0;
      do begin
        @(negedge clk);
        m++;
      end while ((s ? smp : tq) !== 1'b1 && m < 4000);
      if (m >= 4000) begin
        err_count++;
        stop_test();
      end
    end
    `CHK(m, e)
  endtask

  // A clear accept flag leaves index and buffer open, so only it is compared
  task automatic msg_chk(input logic [15:0] h, input logic [3:0] f, input logic [3:0] b, input logic v, input logic a);
    @(posedge clk);
    msg <= 1'b1;
    hit <= h;
    @(posedge clk);
    msg <= 1'b0;
    @(negedge clk);
    if (a) `CHK({acc, afilt, abuf, aval}, {a, f, b, v})
    else `CHK(acc, 1'b0)
  endtask

  task automatic t_regs;
    int k;
    for (k = 0; k < 9; k++) rdchk(4'(k), (k == 6) ? 16'hffff : 16'h0000);
    wp <= 6'h1f;
    rp <= 6'h1e;
    wr16(IDX_FIFO, 16'hffff);
    rdchk(IDX_FIFO, 16'h1f1e);
    wr16(IDX_ENABLE, 16'hffff);
    rdchk(IDX_ENABLE, 16'h00ef);
    wr16(IDX_ENABLE, 16'h0000);
    be <= 4'h2;
    wr16(IDX_FILT_EN, 16'h0000);
    be <= 4'h3;
    rdchk(IDX_FILT_EN, 16'h00ff);
  endtask

  task automatic t_events;
    int k;
    logic [15:0] e;
    for (k = 0; k < 5; k++) begin
      e = 16'(1 << ((k == 4) ? 7 : k));
      pulse(5'(1 << k));
      rdchk(IDX_FLAG, e);
      wr16(IDX_FLAG, 16'h00ff);
      rdchk(IDX_FLAG, e);
      wr16(IDX_FLAG, 16'h0000);
      rdchk(IDX_FLAG, 16'h0000);
    end
    wr16(IDX_ENABLE, 16'h0002);
    pulse(5'h02);
    repeat (2) @(negedge clk);
    `CHK(irq, 1'b1)
    wr16(IDX_FLAG, 16'h0000);
    repeat (3) @(negedge clk);
    `CHK(irq, 1'b0)
    wr16(IDX_ENABLE, 16'h0001);
    pulse(5'h02);
    repeat (3) @(negedge clk);
    `CHK(irq, 1'b0)
    wr16(IDX_FLAG, 16'h0000);
  endtask

  task automatic t_errors;
    tc <= 8'h80;
    rc <= 8'h60;
    bo <= 1'b1;
    wr16(IDX_ERRCNT, 16'hffff);
    rdchk(IDX_ERRCNT, 16'h8060);
    rdchk(IDX_FLAG, 16'h3720);
    wr16(IDX_FLAG, 16'h0000);
    rdchk(IDX_FLAG, 16'h3700);
    tc <= 8'h5f;
    rc <= 8'h7f;
    bo <= 1'b0;
    repeat (6) @(posedge clk);
    rdchk(IDX_FLAG, 16'h0300);
    rdchk(IDX_ERRCNT, 16'h5f7f);
    tc <= 8'h00;
    rc <= 8'h00;
  endtask

  task automatic t_filter;
    wr16(IDX_FILT_EN, 16'hfffe);
    wr16(IDX_BUFSEL, 16'h4321);
    rdchk(IDX_FILT_EN, 16'hfffe);
    msg_chk(16'h0003, 4'h1, 4'h2, 1'b1, 1'b1);
    msg_chk(16'h0008, 4'h3, 4'h4, 1'b1, 1'b1);
    msg_chk(16'h0020, 4'h5, 4'h2, 1'b0, 1'b1);
    msg_chk(16'h0001, 4'h0, 4'h0, 1'b0, 1'b0);
    wr16(IDX_FILT_EN, 16'hffff);
    wr16(IDX_BUFSEL, 16'h0010);
    msg_chk(16'h0001, 4'h0, 4'h0, 1'b1, 1'b1);
    msg_chk(16'h0002, 4'h1, 4'h1, 1'b1, 1'b1);
  endtask

  task automatic t_timing;
    wr16(IDX_PRESCALE, 16'hffc1);
    rdchk(IDX_PRESCALE, 16'h00c1);
    gap(1'b0, 4);
    wr16(IDX_PRESCALE, 16'h003f);
    gap(1'b0, 128);
    wr16(IDX_PRESCALE, 16'h0000);
    gap(1'b0, 2);
    wr16(IDX_SEGMENTS, 16'hffff);
    rdchk(IDX_SEGMENTS, 16'h47ff);
    wr16(IDX_SEGMENTS, 16'h03d1);
    gap(1'b1, 20);
    `CHK(sbit, 1'b1)
    wr16(IDX_SEGMENTS, 16'h0011);
    gap(1'b1, 18);
    @(posedge clk);
    can_bus_model_i.dominant(40);
    `CHK(sbit, 1'b0)
    wr16(IDX_FLAG, 16'h0000);
    wr16(IDX_SEGMENTS, 16'h0000);
  endtask

  task automatic t_wake;
    dis <= 1'b1;
    tc <= 8'h11;
    pulse(5'h02);
    can_bus_model_i.dominant(3);
    repeat (4) @(posedge clk);
    rdchk(IDX_FLAG, 16'h0040);
    rdchk(IDX_ERRCNT, 16'h0000);
    msg_chk(16'h0001, 4'h0, 4'h0, 1'b0, 1'b0);
    wr16(IDX_FLAG, 16'h0000);
    wr16(IDX_SEGMENTS, 16'h4000);
    can_bus_model_i.dominant(50);
    repeat (4) @(posedge clk);
    rdchk(IDX_FLAG, 16'h0000);
    can_bus_model_i.dominant(130);
    repeat (4) @(posedge clk);
    rdchk(IDX_FLAG, 16'h0040);
    wr16(IDX_FLAG, 16'h0000);
    dis <= 1'b0;
    tc <= 8'h00;
  endtask

  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    t_events();
    t_errors();
    t_filter();
    t_timing();
    t_wake();
    stop_test();
  end
endmodule
